// ==== rtl/nsr_pkg.sv ====
// package: register map, commands, pin timing and field layouts for the nand status/reset/id host
package nsr_pkg;
   // host command registers (apb, byte addresses)
   localparam logic [7:0] NSR_REG_CTRL   = 8'h00;
   localparam logic [7:0] NSR_REG_ADDR   = 8'h04;
   localparam logic [7:0] NSR_REG_STATUS = 8'h08;
   localparam logic [7:0] NSR_REG_DATA   = 8'h0c;
   localparam logic [7:0] NSR_REG_ID0    = 8'h10;
   localparam logic [7:0] NSR_REG_ID1    = 8'h14;
   // ctrl fields
   localparam int NSR_CTRL_GO_BIT  = 8;
   localparam int NSR_CTRL_CNT_LSB = 12;
   // device commands
   localparam logic [7:0] NSR_CMD_READ    = 8'h00;
   localparam logic [7:0] NSR_CMD_STATUS  = 8'h70;
   localparam logic [7:0] NSR_CMD_STATENH = 8'h78;
   localparam logic [7:0] NSR_CMD_READID  = 8'h90;
   localparam logic [7:0] NSR_CMD_RESET   = 8'hff;
   localparam logic [7:0] NSR_ID_ADDR     = 8'h00;
   // status byte fields
   localparam int NSR_SB_FAIL = 0;
   localparam int NSR_SB_OTP  = 3;
   localparam int NSR_SB_ECC  = 4;
   localparam int NSR_SB_ARDY = 5;
   localparam int NSR_SB_RDY  = 6;
   localparam int NSR_SB_WPN  = 7;
   localparam logic [7:0] NSR_SB_RST_WPHI = 8'he0;
   localparam logic [7:0] NSR_SB_RST_WPLO = 8'h60;
   // pin timing: each strobe phase lasts this long
   localparam int NSR_CLK_NS     = 50;
   localparam int NSR_PHASE_NS   = 50;
   localparam int NSR_PHASE_CYC  = (NSR_PHASE_NS + NSR_CLK_NS - 1) / NSR_CLK_NS;
   localparam logic [3:0] NSR_PHASE_CNT = 4'(NSR_PHASE_CYC);
   localparam int NSR_ID_MAX     = 5;
   localparam logic [2:0] NSR_ID_MAX3 = 3'(NSR_ID_MAX);
   typedef enum logic [1:0] {NSR_BUS_CMD, NSR_BUS_ADR, NSR_BUS_RD} nsr_bus_e;
endpackage

// ==== rtl/nsr_cyc_if.sv ====
// interface: one nand bus cycle request between sequencer and pin engine
`timescale 1ns/1ps
interface nsr_cyc_if;
   import nsr_pkg::*;
   logic     req;
   nsr_bus_e kind;
   logic [7:0] wdat;
   logic     done;
   logic [7:0] rdat;
   modport seq (output req, kind, wdat, input done, rdat);
   modport eng (input req, kind, wdat, output done, rdat);
endinterface

// ==== rtl/nsr_pin_eng.sv ====
// pin engine: runs one command, address or read cycle on the nand pins
`timescale 1ns/1ps
module nsr_pin_eng
   import nsr_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   nsr_cyc_if.eng          cyc,
   output logic            ce_n_q,
   output logic            cle_q,
   output logic            ale_q,
   output logic            we_n_q,
   output logic            read_strobe_n_q,
   output logic [7:0]      io_out_q,
   output logic            io_oe_q,
   input  wire logic [7:0] io_in
);
   typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} eng_st_e;
   eng_st_e    st_q, st_d;
   logic [3:0] cnt_q, cnt_d;
   logic       ce_d, cle_d, ale_d, we_d, re_d, oe_d, done_d, done_q;
   logic [7:0] io_d, rd_d, rd_q;

   assign cyc.done = done_q;
   assign cyc.rdat = rd_q;

   always_comb begin
      st_d = st_q; cnt_d = cnt_q; ce_d = ce_n_q; cle_d = cle_q; ale_d = ale_q;
      we_d = we_n_q; re_d = read_strobe_n_q; oe_d = io_oe_q; io_d = io_out_q;
      rd_d = rd_q; done_d = 1'b0;
      case (st_q)
         ST_IDLE: if (cyc.req && !done_q) begin
            st_d  = ST_LOW; cnt_d = NSR_PHASE_CNT; ce_d = 1'b0;
            cle_d = (cyc.kind == NSR_BUS_CMD);
            ale_d = (cyc.kind == NSR_BUS_ADR);
            oe_d  = (cyc.kind != NSR_BUS_RD);
            io_d  = cyc.wdat;
            if (cyc.kind == NSR_BUS_RD) re_d = 1'b0;
            else we_d = 1'b0;
         end
         ST_LOW: if (cnt_q > 4'd1) cnt_d = cnt_q - 4'd1;
         else begin
            // data sampled while the read strobe is still low, before it rises
            if (!read_strobe_n_q) rd_d = io_in;
            we_d = 1'b1; re_d = 1'b1; st_d = ST_HIGH; cnt_d = NSR_PHASE_CNT;
         end
         ST_HIGH: if (cnt_q > 4'd1) cnt_d = cnt_q - 4'd1;
         else begin
            cle_d = 1'b0; ale_d = 1'b0; oe_d = 1'b0; done_d = 1'b1; st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE; cnt_q <= 4'h0; ce_n_q <= 1'b1; cle_q <= 1'b0; ale_q <= 1'b0;
         we_n_q <= 1'b1; read_strobe_n_q <= 1'b1; io_oe_q <= 1'b0; io_out_q <= 8'h00;
         rd_q <= 8'h00; done_q <= 1'b0;
      end else begin
         st_q <= st_d; cnt_q <= cnt_d; ce_n_q <= ce_d; cle_q <= cle_d; ale_q <= ale_d;
         we_n_q <= we_d; read_strobe_n_q <= re_d; io_oe_q <= oe_d; io_out_q <= io_d;
         rd_q <= rd_d; done_q <= done_d;
      end
   end
endmodule // nsr_pin_eng

// ==== rtl/nsr_host.sv ====
// host controller: issues status, enhanced status, reset and id sequences to a nand device
// How it works
// - device stays in status mode; host sends 00h before data reads.
// - multi-die shared enable: host uses enhanced status 78h, not 70h; the host's own status read after reset always sends 70h.
// - host sends die/plane address after 78h; status of that plane returns.
// - reset must be the first command after power-on.
// - 90h plus address 00h gives id mode; five or four bytes.
// - after id, host sends dummy 00h before status 70h.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module nsr_host
   import nsr_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             ce_n_q,
   output logic             cle_q,
   output logic             ale_q,
   output logic             we_n_q,
   output logic             read_strobe_n_q,
   output logic [7:0]       io_out_q,
   output logic             io_oe_q,
   input  wire logic [7:0]  io_in,
   input  wire logic        ready_busy_n
);
   typedef enum logic [2:0] {S_IDLE, S_PRE, S_CMD, S_ADR, S_RD, S_WAIT} seq_st_e;
   nsr_cyc_if cyc ();

   seq_st_e    st_q, st_d;
   logic [7:0] cmd_q, cmd_d, adr_q, adr_d, last_q, last_d, stat_q, stat_d;
   logic [2:0] n_q, n_d, idx_q, idx_d;
   logic [7:0] idb_q [NSR_ID_MAX];
   logic [7:0] idb_d [NSR_ID_MAX];
   logic       busy_q, busy_d, rst_seen_q, rst_seen_d, err_q, err_d;
   logic       req_q, req_d;
   nsr_bus_e   kind_q, kind_d;
   logic [7:0] wdat_q, wdat_d;
   logic [31:0] prdata_d;
   logic       pready_d;

   assign cyc.req  = req_q;
   assign cyc.kind = kind_q;
   assign cyc.wdat = wdat_q;

   function automatic logic wr_hit(input logic [7:0] a);
      // a write lands on the edge where the master samples pready high
      wr_hit = psel && penable && pwrite && pready && (paddr == a);
   endfunction

   nsr_pin_eng u_eng (
      .pclk            (pclk),
      .presetn         (presetn),
      .cyc             (cyc),
      .ce_n_q          (ce_n_q),
      .cle_q           (cle_q),
      .ale_q           (ale_q),
      .we_n_q          (we_n_q),
      .read_strobe_n_q (read_strobe_n_q),
      .io_out_q        (io_out_q),
      .io_oe_q         (io_oe_q),
      .io_in           (io_in)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // sequencer
   always_comb begin
      st_d = st_q; cmd_d = cmd_q; adr_d = adr_q; last_d = last_q; stat_d = stat_q;
      n_d = n_q; idx_d = idx_q; busy_d = busy_q; rst_seen_d = rst_seen_q; err_d = err_q;
      req_d = req_q; kind_d = kind_q; wdat_d = wdat_q;
      for (int i = 0; i < NSR_ID_MAX; i++) idb_d[i] = idb_q[i];
      if (wr_hit(NSR_REG_ADDR)) adr_d = pwdata[7:0];
      case (st_q)
         S_IDLE: if (wr_hit(NSR_REG_CTRL) && pwdata[NSR_CTRL_GO_BIT]) begin
            cmd_d = pwdata[7:0];
            n_d = pwdata[NSR_CTRL_CNT_LSB +: 3];
            if (n_d == 3'd0) n_d = 3'd1;
            if (n_d > NSR_ID_MAX3) n_d = NSR_ID_MAX3;
            idx_d = 3'd0; busy_d = 1'b1; err_d = 1'b0;
            // the device ignores anything before its first reset
            if (!rst_seen_q && pwdata[7:0] != NSR_CMD_RESET) begin
               err_d = 1'b1; busy_d = 1'b0;
            end else if (pwdata[7:0] == NSR_CMD_STATUS &&
                         (last_q == NSR_CMD_READID)) begin
               st_d = S_PRE; req_d = 1'b1; kind_d = NSR_BUS_CMD; wdat_d = NSR_CMD_READ;
            end else begin
               st_d = S_CMD; req_d = 1'b1; kind_d = NSR_BUS_CMD; wdat_d = pwdata[7:0];
            end
         end
         S_PRE: if (cyc.done) begin
            st_d = S_CMD; kind_d = NSR_BUS_CMD; wdat_d = cmd_q;
         end
         S_CMD: if (cyc.done) begin
            last_d = cmd_q;
            if (cmd_q == NSR_CMD_RESET) begin
               rst_seen_d = 1'b1; req_d = 1'b0; st_d = S_WAIT;
            end else if (cmd_q == NSR_CMD_READID) begin
               kind_d = NSR_BUS_ADR; wdat_d = NSR_ID_ADDR; st_d = S_ADR;
            end else if (cmd_q == NSR_CMD_STATENH) begin
               kind_d = NSR_BUS_ADR; wdat_d = adr_q; st_d = S_ADR;
            end else if (cmd_q == NSR_CMD_STATUS) begin
               kind_d = NSR_BUS_RD; wdat_d = 8'h00; st_d = S_RD;
            end else begin
               req_d = 1'b0; busy_d = 1'b0; st_d = S_IDLE;
            end
         end
         S_ADR: if (cyc.done) begin
            kind_d = NSR_BUS_RD; wdat_d = 8'h00; st_d = S_RD;
         end
         S_RD: if (cyc.done) begin
            if (cmd_q == NSR_CMD_READID) idb_d[idx_q] = cyc.rdat;
            else stat_d = cyc.rdat;
            if (idx_q + 3'd1 >= n_q) begin
               req_d = 1'b0; busy_d = 1'b0; st_d = S_IDLE;
            end
            idx_d = idx_q + 3'd1;
         end
         // wait out the reset busy time on ready/busy, then read status once
         S_WAIT: if (ready_busy_n) begin
            req_d = 1'b1; kind_d = NSR_BUS_CMD; wdat_d = NSR_CMD_STATUS;
            cmd_d = NSR_CMD_STATUS; n_d = 3'd1; idx_d = 3'd0; st_d = S_CMD;
         end
         default: st_d = S_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, reads are side-effect free
   always_comb begin
      pready_d = psel && penable && !pready;
      prdata_d = 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
         case (paddr)
            NSR_REG_CTRL:   prdata_d = {24'h000000, cmd_q};
            NSR_REG_ADDR:   prdata_d = {24'h000000, adr_q};
            NSR_REG_STATUS: prdata_d = {28'h0000000, rst_seen_q, err_q, ready_busy_n, busy_q};
            NSR_REG_DATA:   prdata_d = {24'h000000, stat_q};
            NSR_REG_ID0:    prdata_d = {idb_q[3], idb_q[2], idb_q[1], idb_q[0]};
            NSR_REG_ID1:    prdata_d = {24'h000000, idb_q[4]};
            default:        prdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= S_IDLE; cmd_q <= 8'h00; adr_q <= 8'h00; last_q <= 8'h00; stat_q <= 8'h00;
         n_q <= 3'd0; idx_q <= 3'd0; busy_q <= 1'b0; rst_seen_q <= 1'b0; err_q <= 1'b0;
         req_q <= 1'b0; kind_q <= NSR_BUS_CMD; wdat_q <= 8'h00;
         for (int i = 0; i < NSR_ID_MAX; i++) idb_q[i] <= 8'h00;
         prdata <= 32'h0000_0000; pready <= 1'b0; pslverr <= 1'b0;
      end else begin
         st_q <= st_d; cmd_q <= cmd_d; adr_q <= adr_d; last_q <= last_d; stat_q <= stat_d;
         n_q <= n_d; idx_q <= idx_d; busy_q <= busy_d; rst_seen_q <= rst_seen_d;
         err_q <= err_d; req_q <= req_d; kind_q <= kind_d; wdat_q <= wdat_d;
         for (int i = 0; i < NSR_ID_MAX; i++) idb_q[i] <= idb_d[i];
         prdata <= prdata_d; pready <= pready_d;
         pslverr <= pready_d && !(paddr inside {NSR_REG_CTRL, NSR_REG_ADDR, NSR_REG_STATUS,
                                                NSR_REG_DATA, NSR_REG_ID0, NSR_REG_ID1});
      end
   end
endmodule // nsr_host

// ==== sim/nsr_nand_model.sv ====
// device model: status, reset and id answers of the nand behind the host
`timescale 1ns/1ps
module nsr_nand_model #(
   parameter int         T_RST = 2000,
   parameter logic [7:0] MAN   = 8'h5a, // arbitrary value
   parameter logic [7:0] DEV   = 8'ha5  // arbitrary value
) (
   input  wire logic       ce_n,
   input  wire logic       cle,
   input  wire logic       ale,
   input  wire logic       we_n,
   input  wire logic       read_strobe_n,
   input  wire logic [7:0] io_out,
   input  wire logic       io_oe,
   input  wire logic       wp,
   input  wire logic [1:0] fail_pl,
   output logic [7:0]      io_in,
   output logic            rb_n
);
   logic [7:0] cmd = 8'h00, adr = 8'h00, lastv = 8'h00, d;
   logic [7:0] ib [5] = '{MAN, DEV, 8'h05, 8'h26, 8'h56};
   logic [1:0] pf = 2'b00;
   logic       in_rst = 1'b0;
   int         idx = 0;
   initial rb_n = 1'b1;
   always_comb begin
      d = {wp, rb_n, rb_n, 4'h0, cmd == 8'h78 ? pf[adr[0]] : |pf};
      if (cmd == 8'h90) d = ib[idx > 4 ? 4 : idx];
      // released bus shows the inverse so a stale sample cannot pass
      io_in = io_oe ? io_out : (!ce_n && !read_strobe_n) ? d : ~lastv;
   end
   always @(posedge read_strobe_n) if (!ce_n) begin
      lastv = d;
      idx++;
   end
   always @(posedge we_n) if (!ce_n) begin
      if (cle && io_out == 8'hff) begin
         if (!in_rst) fork do_rst(); join_none
      end else if (cle && !(cmd == 8'h90 && io_out == 8'h70)) begin
         cmd = io_out;
         idx = 0;
         if (io_out[7:4] == 4'h7) pf = fail_pl;
      end else if (ale) adr = io_out;
   end
   task automatic do_rst();
      in_rst = 1'b1;
      cmd = 8'h00;
      pf = 2'b00;
      rb_n = 1'b0;
      #(T_RST) rb_n = 1'b1;
      in_rst = 1'b0;
   endtask
endmodule // nsr_nand_model

// ==== sim/nsr_host_checker.sv ====
// checker: apb answer timing and nand pin sequencing at the host ports
`timescale 1ns/1ps
module nsr_host_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        ce_n_q,
   input wire logic        we_n_q,
   input wire logic        read_strobe_n_q,
   input wire logic        io_oe_q,
   input wire logic        ready_busy_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_acc; psel && penable && !$past(penable); endsequence
   sequence s_busy2; !ready_busy_n ##1 !ready_busy_n; endsequence
   a_one_wait: assert property (s_acc |=> pready) else $error("late apb answer");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
   a_err_pair: assert property (pslverr |-> pready) else $error("stray pslverr");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
   a_we_frame: assert property (!we_n_q |-> read_strobe_n_q && io_oe_q && !ce_n_q)
      else $error("bad write frame");
   a_we_pulse: assert property ($fell(we_n_q) |=> we_n_q) else $error("write pulse long");
   a_rd_select: assert property ($fell(read_strobe_n_q) |-> !ce_n_q && !io_oe_q ##1
      read_strobe_n_q) else $error("bad read frame");
   a_busy_quiet: assert property (s_busy2 |-> we_n_q && read_strobe_n_q)
      else $error("pins move while busy");
endmodule // nsr_host_checker
bind nsr_host nsr_host_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce_n_q(ce_n_q),
   .we_n_q(we_n_q), .read_strobe_n_q(read_strobe_n_q), .io_oe_q(io_oe_q),
   .ready_busy_n(ready_busy_n));

// ==== sim/tb.sv ====
// bench: drives the status/reset/id host over apb against the device model
`timescale 1ns/1ps
module tb;
   import nsr_pkg::*;
   localparam logic [7:0] MAN = 8'h5a; // arbitrary value
   localparam logic [7:0] DEV = 8'ha5; // arbitrary value
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wp = 1, er;
   logic pready, pslverr, ce_n_q, cle_q, ale_q, we_n_q, read_strobe_n_q, io_oe_q, rb_n;
   logic [7:0]  paddr = 0, io_out_q, io_in, c;
   logic [31:0] pwdata = 0, prdata, rd, r, rs = 15869;
   logic [1:0]  fpl = 0;
   int          n_mismatch = 0, checks = 0, cyc = 0;
   always #25 pclk = ~pclk;
   nsr_host u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ce_n_q(ce_n_q), .cle_q(cle_q), .ale_q(ale_q), .we_n_q(we_n_q),
      .read_strobe_n_q(read_strobe_n_q), .io_out_q(io_out_q), .io_oe_q(io_oe_q),
      .io_in(io_in), .ready_busy_n(rb_n));
   nsr_nand_model #(.MAN(MAN), .DEV(DEV)) u_dev (.ce_n(ce_n_q), .cle(cle_q), .ale(ale_q),
      .we_n(we_n_q), .read_strobe_n(read_strobe_n_q), .io_out(io_out_q), .io_oe(io_oe_q),
      .wp(wp), .fail_pl(fpl), .io_in(io_in), .rb_n(rb_n));
   function logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   function logic [7:0] e3(int ch, int lv); return {4'h0, 2'($clog2(lv) - 1), 2'($clog2(ch))};
   endfunction
   function logic [7:0] e4(int pg, int bk, int sp);
      return {2'b00, 2'($clog2(bk / 64)), 1'b0, 1'(sp / 32), 2'($clog2(pg))};
   endfunction
   function logic [7:0] e5(int ecc, int pl, int mb);
      return {1'b0, 3'($clog2(mb / 64)), 2'($clog2(pl)), 2'($clog2(ecc))};
   endfunction
   task chk(logic [31:0] g, logic [31:0] e, string m);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   task apb(logic w, logic [7:0] a, logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // polls busy so a sequence is complete before its results are read
   task run(logic [7:0] cmd, logic [2:0] n);
      apb(1'b1, NSR_REG_CTRL, {17'h0, n, 3'h0, 1'b1, cmd});
      do apb(1'b0, NSR_REG_STATUS, 32'h0); while (rd[0] !== 1'b0);
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge pclk) if (++cyc == 20000) begin
      n_mismatch++;
      test_done;
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      run(NSR_CMD_STATUS, 3'h0);
      chk({30'h0, rd[3:2]}, 32'h1, "early command taken");
      chk({31'h0, ce_n_q}, 32'h1, "pins moved");
      $display("test early done");
      r = xs();
      for (int i = 0; i < 2; i++) begin
         wp <= r[0] ^ i[0];
         @(posedge pclk);
         run(NSR_CMD_RESET, 3'h0);
         apb(1'b0, NSR_REG_DATA, 32'h0);
         chk(rd, {24'h0, wp ? NSR_SB_RST_WPHI : NSR_SB_RST_WPLO}, "reset status");
      end
      $display("test reset done");
      run(NSR_CMD_READID, 3'h5);
      apb(1'b0, NSR_REG_ID0, 32'h0);
      chk(rd, {e4(4, 256, 32), e3(2, 4), DEV, MAN}, "id low");
      apb(1'b0, NSR_REG_ID1, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, e5(4, 2, 2048)}, "id high");
      $display("test id done");
      for (int i = 0; i < 6; i++) begin
         r = xs();
         fpl <= r[1:0];
         apb(1'b1, NSR_REG_ADDR, {31'h0, r[2]});
         c = (i > 0 && r[3]) ? NSR_CMD_STATENH : NSR_CMD_STATUS;
         run(c, 3'(r[5:4]));
         apb(1'b0, NSR_REG_DATA, 32'h0);
         chk(rd, {24'h0, wp, 2'b11, 4'h0, c == NSR_CMD_STATENH ? fpl[r[2]] : |fpl},
            "status byte");
      end
      $display("test status done");
      apb(1'b0, 8'h20, 32'h0);
      chk({rd[30:0], er}, 32'h1, "unmapped read");
      $display("test unmapped done");
      test_done;
   end
endmodule // tb
